// >>> common/pohc_pkg.sv
// What this block does
// - per-source interrupt enables at bits 7,5,3,1
// - detector events set flags 7,5,3,1
// - flags readable; write one clears
// - input bit reads pin only if digital
// - input state register is read-only
// - digital enable turns pin buffer on
// - analog link forces buffer off in run
// - test enable keeps buffer on in run
// - direct connect keeps buffer off in run
// - pull-up when select, test, not stop
// - bypass acts only with direct connect
// - direct connect acts only with link
// - link routes pin to adc channel
// - two-bit field selects divider ratio
package pohc_pkg;
    localparam logic [11:0] ADDR_IRQ_EN   = 12'h000;
    localparam logic [11:0] ADDR_FLAGS    = 12'h004;
    localparam logic [11:0] ADDR_PIN_IN   = 12'h008;
    localparam logic [11:0] ADDR_DIG_EN   = 12'h00C;
    localparam logic [11:0] ADDR_ANA_CTL  = 12'h010;
    localparam logic [11:0] ADDR_DIV_SEL  = 12'h014;
    localparam logic [7:0]  OC_MASK       = 8'hAA;
    localparam int          BIT_TEST_EN   = 7;
    localparam int          BIT_PULL_SEL  = 6;
    localparam int          BIT_BYPASS    = 5;
    localparam int          BIT_DIRECT    = 4;
    localparam int          BIT_LINK      = 3;
    localparam int          BIT_DIG_EN    = 0;
    localparam int          BIT_PIN_IN    = 0;
    localparam int          BIT_RATIO_HI  = 1;
    localparam int          BIT_RATIO_LO  = 0;
    localparam logic [7:0]  ANA_MASK      = 8'hF8;
    localparam logic [7:0]  DIV_MASK      = 8'h03;
    localparam logic [7:0]  DIG_MASK      = 8'h01;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    typedef enum logic [1:0] {
        POHC_RATIO_HIGH,
        POHC_RATIO_LOW,
        POHC_RATIO_12
    } pohc_ratio_t;
    typedef struct packed {
        logic        buffer_enable;
        logic        pull_up;
        logic        adc_link;
        logic        direct;
        logic        bypass;
        pohc_ratio_t ratio;
    } pohc_analog_t;
endpackage

// >>> design/pohc_top.sv
`timescale 1ns/10ps
`default_nettype none
module pohc_top (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [3:0]            oc_detect,
    input  wire logic                  high_voltage_input_pin,
    input  wire logic                  stop_mode,
    output pohc_pkg::pohc_analog_t     analog_ctl,
    output logic                       irq
);
    logic [7:0]  en_q;
    logic [7:0]  en_d;
    logic [7:0]  flg_q;
    logic [7:0]  flg_d;
    logic [7:0]  dig_q;
    logic [7:0]  dig_d;
    logic [7:0]  ana_q;
    logic [7:0]  ana_d;
    logic [7:0]  div_q;
    logic [7:0]  div_d;
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    logic [7:0]  ev_set;
    logic [3:0]  oc_s1_q;
    logic [3:0]  oc_s1_d;
    logic [3:0]  oc_s2_q;
    logic [3:0]  oc_s2_d;
    logic [3:0]  oc_s3_q;
    logic [3:0]  oc_s3_d;
    logic        pin_s1_q;
    logic        pin_s1_d;
    logic        pin_s2_q;
    logic        pin_s2_d;
    logic        irq_q;
    logic        irq_d;
    logic        wr;
    logic        rd;
    logic        link;
    logic        direct;
    logic        test;
    logic        buf_on;
    logic        dig_on;
    logic [7:0]  pin_state;
    logic [7:0]  pend;

    function automatic logic [7:0] spread(input logic [3:0] v);
        spread = {v[3], 1'b0, v[2], 1'b0, v[1], 1'b0, v[0], 1'b0};
    endfunction

    // one byte register in the low byte of a bus word
    function automatic logic [31:0] word_of(input logic [7:0] v);
        word_of = {24'h000000, v};
    endfunction

    // register offset match
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    // two-bit ratio code, upper bit dominant
    function automatic pohc_pkg::pohc_ratio_t ratio_of(input logic [7:0] v);
        if (v[pohc_pkg::BIT_RATIO_HI])
            ratio_of = pohc_pkg::POHC_RATIO_12;
        else if (v[pohc_pkg::BIT_RATIO_LO])
            ratio_of = pohc_pkg::POHC_RATIO_LOW;
        else
            ratio_of = pohc_pkg::POHC_RATIO_HIGH;
    endfunction

    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign link = ana_q[pohc_pkg::BIT_LINK];
    assign direct = ana_q[pohc_pkg::BIT_DIRECT] & link;
    assign test = ana_q[pohc_pkg::BIT_TEST_EN];
    assign dig_on = dig_q[pohc_pkg::BIT_DIG_EN];
    assign ev_set = spread(oc_s2_q & ~oc_s3_q);

    // buffer gating for run and stop modes
    always_comb begin
        buf_on = 1'b0;
        if (dig_on) begin
            if (!link)
                buf_on = 1'b1;
            else if (stop_mode)
                buf_on = 1'b1;
            else if (test && !direct)
                buf_on = 1'b1;
        end
    end

    // input bit: pin only in pure digital use
    always_comb begin
        pin_state = pohc_pkg::RST_BYTE;
        if (dig_on && !link)
            pin_state[pohc_pkg::BIT_PIN_IN] = pin_s2_q;
        else
            pin_state[pohc_pkg::BIT_PIN_IN] = 1'b1;
    end

    always_comb begin
        analog_ctl.buffer_enable = buf_on;
        analog_ctl.pull_up       = ana_q[pohc_pkg::BIT_PULL_SEL] & test & ~stop_mode;
        analog_ctl.adc_link      = link;
        analog_ctl.direct        = direct;
        analog_ctl.bypass        = ana_q[pohc_pkg::BIT_BYPASS] & direct;
        analog_ctl.ratio         = ratio_of(div_q);
    end

    always_comb begin
        en_d = en_q;
        flg_d = flg_q;
        dig_d = dig_q;
        ana_d = ana_q;
        div_d = div_q;
        rd_d = rd_q;
        if (wr) begin
            case (paddr)
                pohc_pkg::ADDR_IRQ_EN: begin
                    en_d = pwdata[7:0] & pohc_pkg::OC_MASK;
                end
                pohc_pkg::ADDR_FLAGS: begin
                    flg_d = flg_q & ~(pwdata[7:0] & pohc_pkg::OC_MASK);
                end
                pohc_pkg::ADDR_DIG_EN: begin
                    dig_d = pwdata[7:0] & pohc_pkg::DIG_MASK;
                end
                pohc_pkg::ADDR_ANA_CTL: begin
                    ana_d = pwdata[7:0] & pohc_pkg::ANA_MASK;
                end
                pohc_pkg::ADDR_DIV_SEL: begin
                    div_d = pwdata[7:0] & pohc_pkg::DIV_MASK;
                end
                default: begin
                    // input state and unmapped: write ignored
                end
            endcase
        end
        flg_d = flg_d | ev_set;
        if (rd) begin
            case (paddr)
                pohc_pkg::ADDR_IRQ_EN: begin
                    rd_d = word_of(en_q);
                end
                pohc_pkg::ADDR_FLAGS: begin
                    rd_d = word_of(flg_q);
                end
                pohc_pkg::ADDR_PIN_IN: begin
                    rd_d = word_of(pin_state);
                end
                pohc_pkg::ADDR_DIG_EN: begin
                    rd_d = word_of(dig_q);
                end
                pohc_pkg::ADDR_ANA_CTL: begin
                    rd_d = word_of(ana_q);
                end
                pohc_pkg::ADDR_DIV_SEL: begin
                    rd_d = word_of(div_q);
                end
                default: begin
                    rd_d = 32'h00000000;
                end
            endcase
        end
    end

    // detector and pin synchronisers, third detector stage for edges
    always_comb begin
        oc_s1_d  = oc_detect;
        oc_s2_d  = oc_s1_q;
        oc_s3_d  = oc_s2_q;
        pin_s1_d = high_voltage_input_pin;
        pin_s2_d = pin_s1_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_s1_q  <= 4'h0;
            oc_s2_q  <= 4'h0;
            oc_s3_q  <= 4'h0;
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            oc_s1_q  <= oc_s1_d;
            oc_s2_q  <= oc_s2_d;
            oc_s3_q  <= oc_s3_d;
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
        end
    end

    // register group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q  <= pohc_pkg::RST_BYTE;
            flg_q <= pohc_pkg::RST_BYTE;
            dig_q <= pohc_pkg::RST_BYTE;
            ana_q <= pohc_pkg::RST_BYTE;
            div_q <= pohc_pkg::RST_BYTE;
            rd_q  <= 32'h00000000;
        end else begin
            en_q  <= en_d;
            flg_q <= flg_d;
            dig_q <= dig_d;
            ana_q <= ana_d;
            div_q <= div_d;
            rd_q  <= rd_d;
        end
    end

    // request registered from next-state flags, no extra lag
    always_comb begin
        pend  = flg_d & en_d;
        irq_d = |pend;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq    = irq_q;
    assign prdata = rd_q;

    // interrupt and flag checks
    AST_IRQ_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(flg_q & en_q))
        else $error("irq does not follow enabled flags");

    AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (ev_set[7]) |=> flg_q[7])
        else $error("event did not set flag");

    AST_FLAG_SET_ALL: assert property (@(posedge pclk) disable iff (!presetn)
        (ev_set != 8'h00) |=> ((flg_q & $past(ev_set)) == $past(ev_set)))
        else $error("event lost against clear");

    AST_FLAG_SOURCES: assert property (@(posedge pclk) disable iff (!presetn)
        (flg_q & ~pohc_pkg::OC_MASK) == 8'h00)
        else $error("flag outside monitored sources");

    AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit(paddr, pohc_pkg::ADDR_FLAGS) && pwdata[5] && !ev_set[5]) |=> !flg_q[5])
        else $error("write one did not clear flag");

    AST_W0_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        (flg_q[3] && !(wr && hit(paddr, pohc_pkg::ADDR_FLAGS) && pwdata[3])) |=> flg_q[3])
        else $error("flag lost without clear");

    AST_EN_MASK: assert property (@(posedge pclk) disable iff (!presetn)
        (en_d == 8'h00) |=> !irq)
        else $error("masked flag raised irq");

    AST_EN_BITS: assert property (@(posedge pclk) disable iff (!presetn)
        (en_q & ~pohc_pkg::OC_MASK) == 8'h00)
        else $error("enable outside monitored sources");

    // input state checks
    AST_PIN_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        (!dig_on || link) |-> pin_state[pohc_pkg::BIT_PIN_IN])
        else $error("pin bit not one while non-digital");

    AST_PIN_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
        (dig_on && !link) |-> (pin_state[pohc_pkg::BIT_PIN_IN] == pin_s2_q))
        else $error("pin bit not synced pin");

    AST_PIN_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        pin_state[7:1] == 7'h00)
        else $error("unused input bits not zero");

    AST_RO: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit(paddr, pohc_pkg::ADDR_PIN_IN)) |=> $stable(dig_q) && $stable(ana_q))
        else $error("write to input state changed state");

    AST_RO_OTHER: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit(paddr, pohc_pkg::ADDR_PIN_IN)) |=> $stable(en_q) && $stable(div_q))
        else $error("write to input state changed control");

    // buffer and analog path checks
    AST_DIG_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !dig_on |-> !analog_ctl.buffer_enable)
        else $error("buffer on without digital enable");

    AST_DIG_ON: assert property (@(posedge pclk) disable iff (!presetn)
        (dig_on && !link) |-> analog_ctl.buffer_enable)
        else $error("buffer off in digital use");

    AST_BUF_RUN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (link && !stop_mode && !test) |-> !analog_ctl.buffer_enable)
        else $error("buffer on under analog link");

    AST_BUF_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        (dig_on && stop_mode) |-> analog_ctl.buffer_enable)
        else $error("buffer off in stop with enable");

    AST_BUF_STOP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (!dig_on && stop_mode) |-> !analog_ctl.buffer_enable)
        else $error("buffer on in stop without enable");

    AST_TEST_BUF: assert property (@(posedge pclk) disable iff (!presetn)
        (dig_on && link && test && !direct && !stop_mode) |-> analog_ctl.buffer_enable)
        else $error("test enable did not hold buffer");

    AST_TEST_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode |-> (analog_ctl.buffer_enable == dig_on))
        else $error("test enable acted in stop");

    AST_DIRECT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (direct && !stop_mode) |-> !analog_ctl.buffer_enable)
        else $error("buffer on in direct mode");

    AST_PULL: assert property (@(posedge pclk) disable iff (!presetn)
        analog_ctl.pull_up |-> (test && !stop_mode))
        else $error("pull-up outside test run");

    AST_PULL_ON: assert property (@(posedge pclk) disable iff (!presetn)
        (ana_q[pohc_pkg::BIT_PULL_SEL] && test && !stop_mode) |-> analog_ctl.pull_up)
        else $error("pull-up missing in test run");

    AST_BYPASS: assert property (@(posedge pclk) disable iff (!presetn)
        analog_ctl.bypass |-> (link && ana_q[pohc_pkg::BIT_DIRECT]))
        else $error("bypass without direct link");

    AST_BYPASS_ON: assert property (@(posedge pclk) disable iff (!presetn)
        (link && ana_q[pohc_pkg::BIT_DIRECT] && ana_q[pohc_pkg::BIT_BYPASS]) |-> analog_ctl.bypass)
        else $error("bypass missing in direct link");

    AST_DIRECT_LINK: assert property (@(posedge pclk) disable iff (!presetn)
        analog_ctl.direct == (link && ana_q[pohc_pkg::BIT_DIRECT]))
        else $error("direct path outside analog link");

    AST_LINK: assert property (@(posedge pclk) disable iff (!presetn)
        analog_ctl.adc_link == ana_q[pohc_pkg::BIT_LINK])
        else $error("adc link does not follow control");

    // divider ratio checks
    AST_RATIO_12: assert property (@(posedge pclk) disable iff (!presetn)
        div_q[pohc_pkg::BIT_RATIO_HI] |-> (analog_ctl.ratio == pohc_pkg::POHC_RATIO_12))
        else $error("ratio code 1x wrong");

    AST_RATIO_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (!div_q[pohc_pkg::BIT_RATIO_HI] && div_q[pohc_pkg::BIT_RATIO_LO])
        |-> (analog_ctl.ratio == pohc_pkg::POHC_RATIO_LOW))
        else $error("ratio code 01 wrong");

    AST_RATIO_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (!div_q[pohc_pkg::BIT_RATIO_HI] && !div_q[pohc_pkg::BIT_RATIO_LO])
        |-> (analog_ctl.ratio == pohc_pkg::POHC_RATIO_HIGH))
        else $error("ratio code 00 wrong");

    AST_DIV_BITS: assert property (@(posedge pclk) disable iff (!presetn)
        (div_q & ~pohc_pkg::DIV_MASK) == 8'h00)
        else $error("divider register outside field");

    COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    COV_CLEAR: cover property (@(posedge pclk) disable iff (!presetn) flg_q[7] ##1 !flg_q[7]);
    COV_TEST_BUF: cover property (@(posedge pclk) disable iff (!presetn) link && buf_on && !stop_mode);
    COV_STOP_BUF: cover property (@(posedge pclk) disable iff (!presetn) link && buf_on && stop_mode);
    COV_PIN_READ: cover property (@(posedge pclk) disable iff (!presetn)
        rd && hit(paddr, pohc_pkg::ADDR_PIN_IN) && dig_on && !link);
endmodule
`default_nettype wire

// >>> tb/pohc_pins.sv
`timescale 1ns/10ps
`default_nettype none
module pohc_pins (
    input  wire logic       pclk,
    input  wire logic [3:0] fire,
    output logic      [3:0] oc_detect
);
    logic [3:0] s1_q = 4'h0;
    logic [3:0] s2_q = 4'h0;
    // detector level held three cycles per event
    always_ff @(posedge pclk) begin
        s1_q <= fire;
        s2_q <= s1_q;
    end
    assign oc_detect = fire | s1_q | s2_q;
endmodule
`default_nettype wire

// >>> tb/pohc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pohc_top_tb;
    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [11:0]            paddr = 12'h000;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            prdata, q;
    logic                   pready, pslverr, irq;
    logic                   pin = 1'b1;
    logic                   stp = 1'b0;
    logic [3:0]             fire = 4'h0;
    logic [3:0]             oc;
    logic [4:0]             e;
    pohc_pkg::pohc_analog_t actl;
    int                     fails = 0;
    int                     checks_done = 0;
    always #5 pclk = ~pclk;
    pohc_pins u_pins (.pclk(pclk), .fire(fire), .oc_detect(oc));
    pohc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .oc_detect(oc), .high_voltage_input_pin(pin), .stop_mode(stp), .analog_ctl(actl), .irq(irq));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            $display("unexpected %s exp %h got %h", n, x, g);
            fails++;
        end
    endtask
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            stop_test();
        end
    endtask
    task automatic t_regs;
        logic [11:0] ad[7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
        logic [7:0]  rv[7] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0]  mv[7] = '{8'hAA, 8'h00, 8'h01, 8'h01, 8'hF8, 8'h03, 8'h00};
        for (int i = 0; i < 7; i++) begin
            xf(1'b0, ad[i], 32'h0);
            chk("reset", {24'h0, rv[i]}, q);
            chk("pslverr", 32'h0, {31'h0, pslverr});
            xf(1'b1, ad[i], 32'hFFFFFFFF);
            xf(1'b0, ad[i], 32'h0);
            chk("mask", {24'h0, mv[i]}, q);
        end
    endtask
    task automatic t_irq;
        for (int i = 0; i < 4; i++) begin
            xf(1'b1, pohc_pkg::ADDR_FLAGS, 32'hFF);
            xf(1'b1, pohc_pkg::ADDR_IRQ_EN, 32'hAA ^ (32'h2 << (2 * i)));
            @(posedge pclk);
            fire <= 4'h1 << i;
            @(posedge pclk);
            fire <= 4'h0;
            repeat (8) @(posedge pclk);
            xf(1'b0, pohc_pkg::ADDR_FLAGS, 32'h0);
            chk("flag", 32'h2 << (2 * i), q);
            chk("masked", 32'h0, {31'h0, irq});
            xf(1'b1, pohc_pkg::ADDR_IRQ_EN, 32'h2 << (2 * i));
            repeat (2) @(posedge pclk);
            chk("irq", 32'h1, {31'h0, irq});
            xf(1'b1, pohc_pkg::ADDR_FLAGS, 32'h55);
            xf(1'b0, pohc_pkg::ADDR_FLAGS, 32'h0);
            chk("w0 keep", 32'h2 << (2 * i), q);
        end
        xf(1'b1, pohc_pkg::ADDR_FLAGS, 32'h80);
        xf(1'b0, pohc_pkg::ADDR_FLAGS, 32'h0);
        chk("cleared", 32'h0, q);
        repeat (2) @(posedge pclk);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask
    task automatic t_pin;
        xf(1'b1, pohc_pkg::ADDR_ANA_CTL, 32'h0);
        xf(1'b1, pohc_pkg::ADDR_DIG_EN, 32'h1);
        for (int i = 0; i < 3; i++) begin
            pin <= i[0];
            repeat (4) @(posedge pclk);
            xf(1'b0, pohc_pkg::ADDR_PIN_IN, 32'h0);
            chk("pin", {31'h0, i[0]}, q);
        end
        xf(1'b1, pohc_pkg::ADDR_ANA_CTL, 32'h08);
        repeat (2) @(posedge pclk);
        xf(1'b0, pohc_pkg::ADDR_PIN_IN, 32'h0);
        chk("pin analog", 32'h1, q);
    endtask
    task automatic t_ana;
        for (int k = 0; k < 128; k++) begin
            stp <= k[6];
            xf(1'b1, pohc_pkg::ADDR_DIG_EN, {31'h0, k[5]});
            xf(1'b1, pohc_pkg::ADDR_ANA_CTL, {24'h0, k[4:0], 3'h0});
            e[4] = k[5] & (!k[0] | k[6] | (k[4] & !k[1]));
            e[3] = k[3] & k[4] & !k[6];
            e[2:0] = {k[0], k[1] & k[0], k[2] & k[1] & k[0]};
            @(posedge pclk);
            chk("analog", {27'h0, e}, {25'h0, actl[6:2]});
        end
        for (int k = 0; k < 4; k++) begin
            xf(1'b1, pohc_pkg::ADDR_DIV_SEL, k);
            @(posedge pclk);
            chk("ratio", {30'h0, k[1], !k[1] & k[0]}, {30'h0, actl.ratio});
        end
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_irq();
        t_pin();
        t_ana();
        stop_test();
    end
endmodule
`default_nettype wire
